// file: rtl/fwpd_pkg.sv
package fwpd_pkg;
	// ----------------------------------------
	// image offsets
	// ----------------------------------------
	localparam logic [3:0] OFS_GROSS      = 4'h0;
	localparam logic [3:0] OFS_NET        = 4'h4;
	localparam logic [3:0] OFS_RD_XCHG    = 4'h8;
	localparam logic [3:0] OFS_FLAGS      = 4'hC;
	localparam logic [3:0] OFS_IN_STATE   = 4'hE;
	localparam logic [3:0] OFS_OUT_STATE  = 4'hF;
	localparam logic [3:0] OFS_COMMAND    = 4'h0;
	localparam logic [3:0] OFS_OVERRIDE   = 4'h2;
	localparam logic [3:0] OFS_WR_XCHG    = 4'h4;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int FORCE_BIT    = 15;
	localparam int ALIVE_BIT    = 15;
	localparam int NET_MODE_BIT = 10;
	// ----------------------------------------
	// command codes
	// ----------------------------------------
	localparam logic [15:0] CMD_NONE      = 16'h0000;
	localparam logic [15:0] CMD_TARE_ON   = 16'h0007;
	localparam logic [15:0] CMD_ZERO      = 16'h0008;
	localparam logic [15:0] CMD_TARE_OFF  = 16'h0009;
	localparam logic [15:0] CMD_KEY_LOCK  = 16'h0015;
	localparam logic [15:0] CMD_UNLOCK    = 16'h0016;
	localparam logic [15:0] CMD_ALL_LOCK  = 16'h0017;
	localparam logic [15:0] CMD_PT_RD     = 16'h0057;
	localparam logic [15:0] CMD_PT_WR     = 16'h0058;
	localparam logic [15:0] CMD_SP1_RD    = 16'h005A;
	localparam logic [15:0] CMD_SP3_RD    = 16'h005C;
	localparam logic [15:0] CMD_SP1_WR    = 16'h005D;
	localparam logic [15:0] CMD_SP3_WR    = 16'h005F;
	localparam logic [15:0] CMD_SAVE      = 16'h0063;
	localparam logic [15:0] CMD_CAL_ZERO  = 16'h0064;
	localparam logic [15:0] CMD_CAL_FIRST = 16'h0065;
	localparam logic [15:0] CMD_SW_RD     = 16'h0066;
	localparam logic [15:0] CMD_SW_WR     = 16'h0067;
	localparam logic [15:0] CMD_CAL_CANC  = 16'h0068;
	localparam logic [15:0] CMD_CAL_ADD   = 16'h006A;
	localparam logic [15:0] CMD_ID_SEND   = 16'h0078;
	localparam logic [15:0] CMD_PW_SEND   = 16'h0079;
	localparam logic [15:0] CMD_SEED_RD   = 16'h007A;
	localparam logic [15:0] CMD_ID_RD     = 16'h007B;
	localparam logic [15:0] CMD_ID_WR     = 16'h007C;
	localparam logic [15:0] CMD_PT_EN     = 16'h0082;
	// ----------------------------------------
	// setup defaults and timing
	// ----------------------------------------
	localparam logic [6:0]  NODE_DEFAULT   = 7'h01;
	localparam int          RATE_KBPS_DEF  = 10;
	localparam int          CLK_HZ         = 25_000_000;
	localparam int          ALIVE_HALF_MS  = 1000;
	localparam int          ALIVE_CYCLES   = CLK_HZ / 1000 * ALIVE_HALF_MS;
	localparam int          GUARD_MS       = 100;
	localparam int          LIFE_FACTOR    = 4;
	// ----------------------------------------
	// keypad lock states
	// ----------------------------------------
	typedef enum logic [1:0] {FWPD_KEYS_FREE, FWPD_KEYS_LOCK, FWPD_ALL_LOCK} fwpd_lock_e;
endpackage : fwpd_pkg

// file: rtl/fwpd_core.sv
module fwpd_core
	import fwpd_pkg::*;
#(
	parameter int ALIVE_COUNT = fwpd_pkg::ALIVE_CYCLES
) (
	input  wire logic        clock,
	input  wire logic        reset_n,
	// process image write side, from the network stack
	input  wire logic        img_wr_en,
	input  wire logic [3:0]  img_wr_ofs,
	input  wire logic [31:0] img_wr_data,
	// weighing front end
	input  wire logic [31:0] gross_mag,
	input  wire logic [31:0] net_mag,
	input  wire logic [6:0]  fault_flags,
	input  wire logic        gross_neg,
	input  wire logic        net_neg,
	input  wire logic        peak_neg,
	input  wire logic        weight_stable,
	input  wire logic        near_zero,
	input  wire logic [1:0]  input_pins,
	input  wire logic [2:0]  output_func,
	input  wire logic [2:0]  host_driven_output_mode,
	input  wire logic        access_granted,
	input  wire logic [31:0] sample_weight,
	input  wire logic [31:0] password_seed,
	input  wire logic [31:0] ident_code,
	// setup
	input  wire logic [6:0]  node_setting,
	input  wire logic        big_endian_choice,
	// published image
	output logic      [31:0] gross_weight_value,
	output logic      [31:0] net_weight_value,
	output logic      [31:0] read_exchange_word,
	output logic      [15:0] condition_flags,
	output logic      [7:0]  input_state_byte,
	output logic      [7:0]  output_state_byte,
	// actions to the instrument
	output logic      [2:0]  outputs_closed,
	output logic             tare_pulse,
	output logic             zero_pulse,
	output logic             save_pulse,
	output logic             cal_pulse,
	output logic             access_write_pulse,
	output logic      [31:0] sample_write_value,
	output logic      [1:0]  lock_state,
	output logic      [31:0] preset_tare_value,
	output logic             preset_tare_active,
	output logic      [6:0]  node_number
);
	import fwpd_pkg::*;

	// ----------------------------------------
	// host written words
	// ----------------------------------------
	logic [15:0] command_reg;   // command word
	logic [15:0] override_reg;  // output override word
	logic [31:0] wr_xchg_reg;   // write exchange word
	logic [15:0] last_cmd_reg;  // command word of the previous cycle

	// byte order swap used for every written word and the 32-bit published words; flags and state bytes go out unswapped
	function automatic logic [31:0] order32(input logic [31:0] v, input logic be);
		order32 = be ? {v[7:0], v[15:8], v[23:16], v[31:24]} : v;
	endfunction

	wire [31:0] wr_swapped = order32(img_wr_data, big_endian_choice);

	// word writes at their fixed image offsets, one per sync strobe
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			command_reg  <= CMD_NONE;
			override_reg <= 16'h0000;
			wr_xchg_reg  <= 32'h0000_0000;
		end else if (img_wr_en) begin
			if (img_wr_ofs == OFS_COMMAND) begin
				command_reg <= wr_swapped[15:0];
			end
			if (img_wr_ofs == OFS_OVERRIDE) begin
				override_reg <= wr_swapped[15:0];
			end
			if (img_wr_ofs == OFS_WR_XCHG) begin
				wr_xchg_reg <= wr_swapped;
			end
		end
	end

	// ----------------------------------------
	// command decode
	// ----------------------------------------
	// edge on change only; repeat needs a different code in between
	wire cmd_new  = (command_reg != last_cmd_reg) && (command_reg != CMD_NONE);
	wire is_sp_rd = (command_reg >= CMD_SP1_RD) && (command_reg <= CMD_SP3_RD);
	wire is_sp_wr = (command_reg >= CMD_SP1_WR) && (command_reg <= CMD_SP3_WR);
	wire [1:0] sp_rd_idx = 2'(command_reg - CMD_SP1_RD);
	wire [1:0] sp_wr_idx = 2'(command_reg - CMD_SP1_WR);
	// protected codes, refused without access
	wire is_prot = (command_reg == CMD_CAL_ZERO) || (command_reg == CMD_CAL_FIRST)
		|| (command_reg == CMD_CAL_CANC) || (command_reg == CMD_CAL_ADD)
		|| (command_reg == CMD_ID_WR);
	wire prot_ok = !is_prot || access_granted;  // grant is volatile upstream
	wire act     = cmd_new && prot_ok;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			last_cmd_reg <= CMD_NONE;
		end else begin
			last_cmd_reg <= command_reg;
		end
	end

	// ----------------------------------------
	// setpoints and preset tare, volatile
	// ----------------------------------------
	logic [31:0] setpoint_reg [3];  // scaled unsigned, no point
	logic [31:0] pt_reg;
	logic        pt_act_reg;
	logic        tare_reg;          // net display mode
	fwpd_lock_e  lock_reg;

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_sp
			// write code stores only from write word
			always_ff @(posedge clock or negedge reset_n) begin
				if (!reset_n) begin
					setpoint_reg[gi] <= 32'h0000_0000;
				end else if (act && is_sp_wr && sp_wr_idx == 2'(gi)) begin
					setpoint_reg[gi] <= wr_xchg_reg;
				end
			end
		end
	endgenerate

	// tare, lock and preset tare actions
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			tare_reg   <= 1'b0;
			lock_reg   <= FWPD_KEYS_FREE;
			pt_reg     <= 32'h0000_0000;
			pt_act_reg <= 1'b0;
		end else if (act) begin
			unique case (command_reg)
				CMD_TARE_ON:  tare_reg   <= 1'b1;
				CMD_TARE_OFF: begin
					tare_reg   <= 1'b0;
					pt_act_reg <= 1'b0;
				end
				CMD_KEY_LOCK: lock_reg   <= FWPD_KEYS_LOCK;
				CMD_UNLOCK:   lock_reg   <= FWPD_KEYS_FREE;
				CMD_ALL_LOCK: lock_reg   <= FWPD_ALL_LOCK;
				CMD_PT_WR:    pt_reg     <= wr_xchg_reg;
				CMD_PT_EN: begin
					pt_act_reg <= 1'b1;
					tare_reg   <= 1'b1;
				end
				default:      tare_reg   <= tare_reg;  // others leave state
			endcase
		end
	end

	// read word mux; only read codes change it
	wire rd_hit = act && (is_sp_rd || command_reg == CMD_PT_RD || command_reg == CMD_SW_RD
		|| command_reg == CMD_SEED_RD || command_reg == CMD_ID_RD);
	wire [31:0] rd_value = is_sp_rd                    ? setpoint_reg[sp_rd_idx] :
		(command_reg == CMD_PT_RD)   ? pt_reg :
		(command_reg == CMD_SW_RD)   ? sample_weight :
		(command_reg == CMD_SEED_RD) ? password_seed : ident_code;

	// ----------------------------------------
	// alive toggle, one second per phase
	// ----------------------------------------
	logic [24:0] alive_cnt;
	logic        alive_reg;
	wire         alive_tick = (alive_cnt == 25'(ALIVE_COUNT - 1));
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			alive_cnt <= 25'h0000000;
			alive_reg <= 1'b0;
		end else if (alive_tick) begin
			alive_cnt <= 25'h0000000;
			alive_reg <= ~alive_reg;
		end else begin
			alive_cnt <= alive_cnt + 25'h0000001;
		end
	end

	// ----------------------------------------
	// outputs: host drive per mode or forced
	// ----------------------------------------
	wire       force_all = override_reg[FORCE_BIT];
	wire [2:0] host_sel  = force_all ? 3'h7 : host_driven_output_mode;
	wire [2:0] out_next  = (host_sel & override_reg[2:0]) | (~host_sel & output_func);

	// input pins: three stage, change taken when stages 2 and 3 agree
	logic [1:0] in_s1, in_s2, in_s3, in_stable;

	// status word assembly
	wire [15:0] flags_next = {alive_reg, 2'b00, near_zero, weight_stable, tare_reg,
		peak_neg, net_neg, gross_neg, fault_flags};

	// ----------------------------------------
	// published image registers
	// ----------------------------------------
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			in_s1              <= 2'h0;
			in_s2              <= 2'h0;
			in_s3              <= 2'h0;
			in_stable          <= 2'h0;
			gross_weight_value <= 32'h0000_0000;
			net_weight_value   <= 32'h0000_0000;
			read_exchange_word <= 32'h0000_0000;
			condition_flags    <= 16'h0000;
			input_state_byte   <= 8'h00;
			output_state_byte  <= 8'h00;
			outputs_closed     <= 3'h0;
		end else begin
			in_s1              <= input_pins;
			in_s2              <= in_s1;
			in_s3              <= in_s2;
			in_stable          <= (in_s2 == in_s3) ? in_s3 : in_stable;
			gross_weight_value <= order32(gross_mag, big_endian_choice);
			net_weight_value   <= order32(net_mag, big_endian_choice);
			if (rd_hit) begin
				read_exchange_word <= order32(rd_value, big_endian_choice);
			end
			condition_flags    <= flags_next;
			input_state_byte   <= {6'h00, in_stable};
			output_state_byte  <= {5'h00, out_next};
			outputs_closed     <= out_next;
		end
	end

	// ----------------------------------------
	// action strobes
	// ----------------------------------------
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			tare_pulse         <= 1'b0;
			zero_pulse         <= 1'b0;
			save_pulse         <= 1'b0;
			cal_pulse          <= 1'b0;
			access_write_pulse <= 1'b0;
			sample_write_value <= 32'h0000_0000;
			node_number        <= NODE_DEFAULT;
		end else begin
			tare_pulse         <= act && (command_reg == CMD_TARE_ON);
			zero_pulse         <= act && (command_reg == CMD_ZERO);
			save_pulse         <= act && (command_reg == CMD_SAVE);
			cal_pulse          <= act && is_prot && (command_reg != CMD_ID_WR);
			access_write_pulse <= act && (command_reg == CMD_ID_WR);
			if (act && command_reg == CMD_SW_WR) begin
				sample_write_value <= wr_xchg_reg;
			end
			node_number        <= (node_setting == 7'h00) ? NODE_DEFAULT : node_setting;
		end
	end

	assign lock_state         = lock_reg;
	assign preset_tare_value  = pt_reg;
	assign preset_tare_active = pt_act_reg;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	AST_REPEAT: assert property (@(posedge clock) disable iff (!reset_n)
		command_reg == $past(command_reg) |-> !cmd_new) else $error("repeat acted");
	AST_PROT: assert property (@(posedge clock) disable iff (!reset_n)
		cmd_new && is_prot && !access_granted |=> !cal_pulse && !access_write_pulse)
		else $error("protected code ran");
	AST_FORCE: assert property (@(posedge clock) disable iff (!reset_n)
		force_all |=> outputs_closed == $past(override_reg[2:0])) else $error("force");
	AST_ZERO: assert property (@(posedge clock) disable iff (!reset_n)
		act && command_reg == CMD_ZERO |=> zero_pulse ##1 !zero_pulse) else $error("zero");
	AST_READ: assert property (@(posedge clock) disable iff (!reset_n)
		!rd_hit |=> $stable(read_exchange_word)) else $error("read word moved");
	AST_SPWR: assert property (@(posedge clock) disable iff (!reset_n)
		act && command_reg == CMD_SP1_WR |=> setpoint_reg[0] == $past(wr_xchg_reg))
		else $error("setpoint write");
	AST_PTEN: assert property (@(posedge clock) disable iff (!reset_n)
		act && command_reg == CMD_PT_EN |=> preset_tare_active && tare_reg)
		else $error("preset tare");
	AST_ALIVE: assert property (@(posedge clock) disable iff (!reset_n)
		alive_tick |=> ##1 condition_flags[ALIVE_BIT] != $past(condition_flags[ALIVE_BIT]))
		else $error("alive");
	AST_FLAGS: assert property (@(posedge clock) disable iff (!reset_n)
		##1 condition_flags[NET_MODE_BIT] == $past(tare_reg)) else $error("net mode");
	CV_FORCE: cover property (@(posedge clock) force_all);
	CV_READ:  cover property (@(posedge clock) rd_hit && is_sp_rd);
	CV_REFUSE: cover property (@(posedge clock) cmd_new && is_prot && !access_granted);
endmodule : fwpd_core

// file: tb/fwpd_master_model.sv
// ----------------------------------------
// network master stand-in
// ----------------------------------------
module fwpd_master_model (
	input  wire logic        clock,
	input  wire logic        reset_n,
	output logic             img_wr_en,
	output logic      [3:0]  img_wr_ofs,
	output logic      [31:0] img_wr_data
);
	timeunit 1ns;
	timeprecision 1ns;
	// node guarding set up the way the slave expects it
	localparam int GUARD_TIME_MS = 100;
	localparam int LIFETIME_FACT = 4;
	// idle bus: strobe low, nothing valid
	initial begin
		img_wr_en   = 1'b0;
		img_wr_ofs  = 4'h0;
		img_wr_data = 32'h0000_0000;
	end
	// one image word per call, taken at the edge after the strobe rises
	task automatic put(input logic [3:0] ofs, input logic [31:0] data);
		@(posedge clock);
		img_wr_en   <= 1'b1;
		img_wr_ofs  <= ofs;
		img_wr_data <= data;
		@(posedge clock);
		img_wr_en   <= 1'b0;
		// scramble released data so a stale word never looks valid
		img_wr_data <= ~data;
	endtask
endmodule // fwpd_master_model

// file: tb/fieldbus_weigh_process_data_tb.sv
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin miscompares++; \
	$display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp); end end
module fieldbus_weigh_process_data_tb;
	import fwpd_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic        clock, reset_n, img_wr_en, gross_neg, net_neg, peak_neg;
	logic        weight_stable, near_zero, access_granted, big_endian_choice;
	logic        tare_pulse, zero_pulse, save_pulse, cal_pulse, access_write_pulse;
	logic        preset_tare_active;
	logic [3:0]  img_wr_ofs;
	logic [31:0] img_wr_data, gross_mag, net_mag, sample_weight, password_seed, ident_code;
	logic [31:0] gross_weight_value, net_weight_value, read_exchange_word;
	logic [31:0] sample_write_value, preset_tare_value;
	logic [6:0]  fault_flags, node_setting, node_number;
	logic [1:0]  input_pins, lock_state;
	logic [2:0]  output_func, host_driven_output_mode, outputs_closed;
	logic [15:0] condition_flags;
	logic [7:0]  input_state_byte, output_state_byte;
	logic [7:0]  tare_cnt, zero_cnt, save_cnt, cal_cnt, acc_cnt; // pulse tallies
	int          miscompares, samples_checked;
	// ----------------------------------------
	// clock, partner, design
	// ----------------------------------------
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	fwpd_master_model master_u (.clock(clock), .reset_n(reset_n), .img_wr_en(img_wr_en),
		.img_wr_ofs(img_wr_ofs), .img_wr_data(img_wr_data));
	// short alive phase keeps the run small
	fwpd_core #(.ALIVE_COUNT(10)) dut_u (.clock(clock), .reset_n(reset_n),
		.img_wr_en(img_wr_en), .img_wr_ofs(img_wr_ofs), .img_wr_data(img_wr_data),
		.gross_mag(gross_mag), .net_mag(net_mag), .fault_flags(fault_flags),
		.gross_neg(gross_neg), .net_neg(net_neg), .peak_neg(peak_neg),
		.weight_stable(weight_stable), .near_zero(near_zero), .input_pins(input_pins),
		.output_func(output_func), .host_driven_output_mode(host_driven_output_mode),
		.access_granted(access_granted), .sample_weight(sample_weight),
		.password_seed(password_seed), .ident_code(ident_code), .node_setting(node_setting),
		.big_endian_choice(big_endian_choice), .gross_weight_value(gross_weight_value),
		.net_weight_value(net_weight_value), .read_exchange_word(read_exchange_word),
		.condition_flags(condition_flags), .input_state_byte(input_state_byte),
		.output_state_byte(output_state_byte), .outputs_closed(outputs_closed),
		.tare_pulse(tare_pulse), .zero_pulse(zero_pulse), .save_pulse(save_pulse),
		.cal_pulse(cal_pulse), .access_write_pulse(access_write_pulse),
		.sample_write_value(sample_write_value), .lock_state(lock_state),
		.preset_tare_value(preset_tare_value), .preset_tare_active(preset_tare_active),
		.node_number(node_number));
	// count one-cycle pulses; a stuck pulse shows as an over-count
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			{tare_cnt, zero_cnt, save_cnt, cal_cnt, acc_cnt} <= '0;
		end else begin
			tare_cnt <= tare_cnt + tare_pulse;
			zero_cnt <= zero_cnt + zero_pulse;
			save_cnt <= save_cnt + save_pulse;
			cal_cnt  <= cal_cnt + cal_pulse;
			acc_cnt  <= acc_cnt + access_write_pulse;
		end
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// land past all latencies, sample on the quiet edge
	// pins need five edges through the synchroniser and the image flop
	task automatic settle;
		repeat (6) @(posedge clock);
		@(negedge clock);
	endtask
	task automatic cmd(input logic [15:0] code);
		master_u.put(OFS_COMMAND, {16'h0000, code});
		settle();
	endtask
	task automatic final_report;
		$display("checked %0d mismatched %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_image;
		@(posedge clock);
		{gross_mag, net_mag} <= {32'h0001_86A0, 32'h0000_0BB8};
		{fault_flags, gross_neg, net_neg, peak_neg} <= {7'h55, 3'b101};
		{weight_stable, near_zero, input_pins} <= {2'b10, 2'b10};
		settle();
		`CHK(gross_weight_value, 32'h0001_86A0)
		`CHK(net_weight_value, 32'h0000_0BB8)
		`CHK(condition_flags[14:0], 15'h0AD5)
		`CHK(input_state_byte, 8'h02)
	endtask
	task automatic t_outputs;
		@(posedge clock);
		{output_func, host_driven_output_mode} <= {3'b100, 3'b011};
		master_u.put(OFS_OVERRIDE, 32'h0000_0002);
		settle();
		`CHK(outputs_closed, 3'b110)
		`CHK(output_state_byte, 8'h06)
		master_u.put(OFS_OVERRIDE, 32'h0000_8001);
		settle();
		`CHK(outputs_closed, 3'b001)
	endtask
	task automatic t_commands;
		cmd(CMD_TARE_ON);
		`CHK(tare_cnt, 8'h01)
		`CHK(condition_flags[NET_MODE_BIT], 1'b1)
		cmd(CMD_TARE_ON);
		`CHK(tare_cnt, 8'h01)
		cmd(CMD_NONE); // separator before repeating
		cmd(CMD_TARE_ON);
		`CHK(tare_cnt, 8'h02)
		cmd(CMD_TARE_OFF);
		`CHK(condition_flags[NET_MODE_BIT], 1'b0)
		cmd(CMD_ZERO);
		`CHK(zero_cnt, 8'h01)
		cmd(CMD_KEY_LOCK);
		`CHK(lock_state, 2'h1)
		cmd(CMD_ALL_LOCK);
		`CHK(lock_state, 2'h2)
		cmd(CMD_UNLOCK);
		`CHK(lock_state, 2'h0)
	endtask
	task automatic t_exchange;
		// exchange value always loaded before its write code
		master_u.put(OFS_WR_XCHG, 32'h0000_07D0);
		cmd(CMD_SP1_WR);
		master_u.put(OFS_WR_XCHG, 32'h0000_0BB8);
		cmd(CMD_SP3_WR);
		master_u.put(OFS_WR_XCHG, 32'h0000_1388);
		cmd(16'h005E); // setpoint 2 write
		cmd(16'h005B); // setpoint 2 read
		`CHK(read_exchange_word, 32'h0000_1388)
		cmd(CMD_SP1_RD);
		`CHK(read_exchange_word, 32'h0000_07D0)
		cmd(CMD_SP3_RD);
		`CHK(read_exchange_word, 32'h0000_0BB8)
		master_u.put(OFS_WR_XCHG, 32'hFFFF_FFC8);
		cmd(CMD_SW_WR);
		`CHK(sample_write_value, 32'hFFFF_FFC8)
		`CHK(read_exchange_word, 32'h0000_0BB8)
		cmd(16'h0005); // undefined code
		`CHK(read_exchange_word, 32'h0000_0BB8)
		cmd(CMD_SW_RD);
		`CHK(read_exchange_word, 32'h0000_0111)
		cmd(CMD_SEED_RD);
		`CHK(read_exchange_word, 32'h0000_0222)
		cmd(CMD_ID_RD);
		`CHK(read_exchange_word, 32'h0000_0333)
		master_u.put(OFS_WR_XCHG, 32'h0000_0064);
		cmd(CMD_PT_WR);
		`CHK(preset_tare_value, 32'h0000_0064)
		cmd(CMD_PT_RD);
		`CHK(read_exchange_word, 32'h0000_0064)
		cmd(CMD_PT_EN);
		`CHK(preset_tare_active, 1'b1)
		cmd(CMD_TARE_OFF); // gross display drops the preset
		`CHK(preset_tare_active, 1'b0)
		cmd(CMD_SAVE);
		`CHK(save_cnt, 8'h01)
	endtask
	task automatic t_access;
		logic [15:0] cal_codes [4];
		cal_codes = '{CMD_CAL_ZERO, CMD_CAL_FIRST, CMD_CAL_CANC, CMD_CAL_ADD};
		foreach (cal_codes[i]) cmd(cal_codes[i]);
		cmd(CMD_ID_WR);
		`CHK(cal_cnt, 8'h00)
		`CHK(acc_cnt, 8'h00)
		@(posedge clock);
		access_granted <= 1'b1;
		foreach (cal_codes[i]) cmd(cal_codes[i]);
		cmd(CMD_ID_WR);
		`CHK(cal_cnt, 8'h04)
		`CHK(acc_cnt, 8'h01)
		// grant gone again, as after power off: refused once more
		@(posedge clock);
		access_granted <= 1'b0;
		cmd(CMD_CAL_ZERO);
		`CHK(cal_cnt, 8'h04)
	endtask
	task automatic t_alive;
		logic level;
		int   n;
		// first pass finds an edge, second measures a whole phase
		@(negedge clock);
		for (int k = 0; k < 2; k++) begin
			level = condition_flags[ALIVE_BIT];
			n = 0;
			while (condition_flags[ALIVE_BIT] === level && n < 30) begin
				@(negedge clock);
				n++;
			end
		end
		`CHK(n, 10)
		if (n >= 30) final_report();
	endtask
	task automatic t_endian;
		@(posedge clock);
		big_endian_choice <= 1'b1;
		settle();
		`CHK(gross_weight_value, 32'hA086_0100)
		`CHK(node_number, 7'h01)
		@(posedge clock);
		node_setting <= 7'h05;
		master_u.put(OFS_COMMAND, 32'h0700_0000);
		settle();
		`CHK(tare_cnt, 8'h03)
		`CHK(node_number, 7'h05)
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{reset_n, gross_mag, net_mag, fault_flags, gross_neg, net_neg, peak_neg} = '0;
		{weight_stable, near_zero, input_pins, output_func} = '0;
		{host_driven_output_mode, access_granted, node_setting, big_endian_choice} = '0;
		{sample_weight, password_seed, ident_code} = {32'h111, 32'h222, 32'h333};
		{miscompares, samples_checked} = '0;
		repeat (10) @(posedge clock);
		reset_n <= 1'b1;
		t_image();
		t_outputs();
		t_commands();
		t_exchange();
		t_access();
		t_alive();
		t_endian();
		final_report();
	end
endmodule // fieldbus_weigh_process_data_tb
